// >>> include/eiu_consts.vh
// Constants of the extended interrupt unit: register offsets, bit positions, reset values, timing
// Summary of operation
// - Lines two to five flags set on their edge, cleared only by software writes.
// - Software setting line, power-fail or watchdog flag requests like hardware when enabled.
// - Serial port one rate doubler bit doubles serial port one baud rate.
// - Power-fail enable bit gates power-fail requests; zero blocks, one passes.
// - Power-fail flag set on active input; still set at return requests again.
// - Watchdog flag set on edge; uncleared at return requests again.
// - Extended enable register: bit 4 watchdog, bits 3..0 lines five..two.
// - Extended priority register: bit 4 watchdog, bits 3..0 lines five..two; one high.
// - Each source vectors to fixed address; power-fail 33h, steps of 8h, watchdog 63h.
// - Low routine preempted only by high or power-fail; high only by power-fail.
// - Finish current instruction; after return or enable/priority write, run one more.
// - Global mask bit masks all but power-fail; power-fail follows own enable only.
// - Power-fail alone takes highest level; others high or low only.
// - Same-level simultaneous requests resolved by lowest natural number, 0 to 12.
// - Standard sources map to timer control, standard enable and priority bits.
// - External inputs sampled once per instruction cycle at end of fourth phase.
// - Lines zero and one: type zero sets on low sample, one on high-low.
// - Lines two and four rise-detected, three and five fall-detected; edge only.
// - Power-fail level active high, watchdog edge active high, sampled per cycle.
// - Seven standard sources plus six extra sources supported.
// - Fastest response five instruction cycles: one detect, four for the call.
`ifndef EIU_CONSTS_VH
`define EIU_CONSTS_VH

`define EIU_ADDR_TIMER_CONTROL 8'h88
`define EIU_ADDR_FLAG          8'h91
`define EIU_ADDR_STD_ENABLE    8'ha8
`define EIU_ADDR_STD_PRIORITY  8'hb8
`define EIU_ADDR_CONTROL       8'hd8
`define EIU_ADDR_ENABLE        8'he8
`define EIU_ADDR_PRIORITY      8'hf8

`define EIU_RST_STD_ENABLE   8'h00
`define EIU_RST_STD_PRIORITY 7'h00
`define EIU_RST_EXT_ENABLE   5'h00
`define EIU_RST_EXT_PRIORITY 5'h00
`define EIU_RST_LINE_FLAGS   4'h0
`define EIU_RST_TIMER_LOW    4'h0

`define EIU_BIT_GLOBAL_MASK   7
`define EIU_BIT_RATE_DOUBLER  7
`define EIU_BIT_PF_ENABLE     5
`define EIU_BIT_PF_FLAG       4
`define EIU_BIT_WD_FLAG       3
`define EIU_BIT_LINE0_TRIGGER 0
`define EIU_BIT_LINE0_FLAG    1
`define EIU_BIT_LINE1_TRIGGER 2
`define EIU_BIT_LINE1_FLAG    3
`define EIU_BIT_TIMER0_FLAG   5
`define EIU_BIT_TIMER1_FLAG   7

`define EIU_NUM_SOURCES 13
`define EIU_NUM_PINS    8
`define EIU_PHASE_LAST  2'h3
`define EIU_SLOT_PF     4'h6

`define EIU_LEVEL_LOW     2'h0
`define EIU_LEVEL_HIGH    2'h1
`define EIU_LEVEL_HIGHEST 2'h2
`define EIU_LEVEL_NONE    2'h3

`endif

// >>> hdl/eiu_pin_sampler.v
// Three-stage pin synchroniser with a once-per-instruction-cycle sample register
`timescale 1ns/1ps
`default_nettype none
module eiu_pin_sampler #(
	parameter WIDTH = 8
) (
	input  wire             clk_sys,
	input  wire             rst_b,
	input  wire [WIDTH-1:0] pinIn,
	input  wire             sampleStrobe,
	output reg  [WIDTH-1:0] curSample,
	output reg  [WIDTH-1:0] prevSample,
	output reg              sampleValid
);
	wire [WIDTH-1:0] stable;

	////////////////////////////////////////////////////////////////////////////
	// Per-pin synchroniser; a change only counts once stages two and three agree
	genvar g;
	generate
		for (g = 0; g < WIDTH; g = g + 1) begin : gSync
			reg syncA;
			reg syncB;
			reg syncC;
			reg held;
			always @(posedge clk_sys or negedge rst_b) begin
				if (!rst_b) begin
					syncA <= 1'b0;
					syncB <= 1'b0;
					syncC <= 1'b0;
					held  <= 1'b0;
				end else begin
					syncA <= pinIn[g];
					syncB <= syncA;
					syncC <= syncB;
					if (syncB == syncC) begin
						held <= syncC;
					end
				end
			end
			assign stable[g] = held;
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Sample at the strobe edge; previous sample kept for edge detection
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			curSample   <= {WIDTH{1'b0}};
			prevSample  <= {WIDTH{1'b0}};
			sampleValid <= 1'b0;
		end else begin
			sampleValid <= sampleStrobe;
			if (sampleStrobe) begin
				curSample  <= stable;
				prevSample <= curSample;
			end
		end
	end
endmodule // eiu_pin_sampler
`default_nettype wire

// >>> hdl/eiu_priority_resolver.v
// Combinational level and natural-order priority resolver for thirteen sources
`timescale 1ns/1ps
`default_nettype none
`include "eiu_consts.vh"
module eiu_priority_resolver (
	input  wire [12:0] reqVec,
	input  wire [12:0] highVec,
	output reg         winValid,
	output reg  [3:0]  winIndex,
	output reg  [1:0]  winLevel
);
	wire [12:0] highReq;
	wire [12:0] lowReq;

	// Lowest set index wins; rank 0 is the natural first
	function [3:0] firstSet;
		input [12:0] vec;
		integer i;
		begin
			firstSet = 4'h0;
			for (i = 12; i >= 0; i = i - 1) begin
				if (vec[i]) begin
					firstSet = i[3:0];
				end
			end
		end
	endfunction

	// Power-fail never joins the high or low groups
	assign highReq = {reqVec[12:1] & highVec[12:1], 1'b0};
	assign lowReq  = {reqVec[12:1] & ~highVec[12:1], 1'b0};

	////////////////////////////////////////////////////////////////////////////
	// Level first, natural order second
	always @* begin
		winValid = 1'b1;
		winIndex = 4'h0;
		winLevel = `EIU_LEVEL_HIGHEST;
		if (reqVec[0]) begin
			winLevel = `EIU_LEVEL_HIGHEST;
		end else if (|highReq) begin
			winIndex = firstSet(highReq);
			winLevel = `EIU_LEVEL_HIGH;
		end else if (|lowReq) begin
			winIndex = firstSet(lowReq);
			winLevel = `EIU_LEVEL_LOW;
		end else begin
			winValid = 1'b0;
			winLevel = `EIU_LEVEL_NONE;
		end
	end
endmodule // eiu_priority_resolver
`default_nettype wire

// >>> hdl/eiu_top.v
// Extended interrupt unit: pin sampling, flags, enables, priorities, in-service tracking, vectoring
`timescale 1ns/1ps
`default_nettype none
`include "eiu_consts.vh"
module eiu_top (
	input  wire       clk_sys,
	input  wire       rst_b,
	// Special-function register port
	input  wire [7:0] sfrAddr,
	input  wire [7:0] sfrWrData,
	input  wire       sfrWrite,
	output reg  [7:0] sfrReadData,
	output reg        sfrHit,
	// External request pins
	input  wire       ext_line0_low,
	input  wire       ext_line1_low,
	input  wire       ext_line2_high,
	input  wire       ext_line3_low,
	input  wire       ext_line4_high,
	input  wire       ext_line5_low,
	input  wire       powerFailIn,
	input  wire       watchdogIn,
	// Flags owned by timer and serial blocks
	input  wire       timer0_overflow_flag,
	input  wire       timer1_overflow_flag,
	input  wire       timer2_overflow_flag,
	input  wire       timer2_external_flag,
	input  wire       serial0_tx_flag,
	input  wire       serial0_rx_flag,
	input  wire       serial1_tx_flag,
	input  wire       serial1_rx_flag,
	// Instruction sequencer
	input  wire       instrDone,
	input  wire       return_from_isr,
	input  wire       irqAck,
	output reg        irqRequest,
	output reg  [7:0] irqVector,
	output reg  [3:0] irqSource,
	output reg        phaseC4,
	output reg        serial1_rate_doubler
);
	////////////////////////////////////////////////////////////////////////////
	// Register storage
	reg  [7:0]  std_enable_reg;
	reg  [6:0]  std_priority_reg;
	reg  [3:0]  timerControlLow;
	reg  [3:0]  lineFlags;
	reg         power_fail_enable;
	reg         powerFailFlag;
	reg         watchdogFlag;
	reg  [4:0]  ext_irq_enable_reg;
	reg  [4:0]  ext_irq_priority_reg;
	reg  [1:0]  phase;
	reg  [2:0]  inService;
	reg         pendingHold;
	reg         holdOff;

	wire [7:0]  ext_irq_flag_reg;
	wire [7:0]  ext_irq_control_reg;
	wire [7:0]  pinActive;
	wire [7:0]  curSample;
	wire [7:0]  prevSample;
	wire        sampleValid;
	wire [7:0]  risingSample;
	wire [12:0] reqVec;
	wire [12:0] highVec;
	wire        winValid;
	wire [3:0]  winIndex;
	wire [1:0]  winLevel;
	wire        global_mask_bit;
	wire        line0_trigger_type;
	wire        line1_trigger_type;
	wire        line0_flag;
	wire        line1_flag;
	wire        wrTimer;
	wire        wrFlag;
	wire        wrStdEnable;
	wire        wrStdPriority;
	wire        wrControl;
	wire        wrEnable;
	wire        wrPriority;
	wire        holdEvent;
	wire [1:0]  activeLevel;
	wire        canPreempt;
	wire        line0Set;
	wire        line1Set;
	wire        line0AckClear;
	wire        line1AckClear;
	wire [3:0]  lineSet;

	reg  [3:0]  next_timerControlLow;
	reg  [3:0]  next_lineFlags;
	reg         next_powerFailFlag;
	reg         next_watchdogFlag;
	reg  [7:0]  next_readData;
	reg         next_hit;

	// Slot of the vector table for each natural rank; power-fail sits between timer 2 and serial 1
	function [3:0] slotOf;
		input [3:0] rank;
		begin
			if (rank == 4'h0) begin
				slotOf = `EIU_SLOT_PF;
			end else if (rank <= 4'h6) begin
				slotOf = rank - 4'h1;
			end else begin
				slotOf = rank;
			end
		end
	endfunction

	// Address compare, shared by every register strobe
	function isAddr;
		input [7:0] addr;
		input [7:0] target;
		begin
			isAddr = (addr == target);
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Instruction-cycle phase; phase three is the fourth clock of the cycle
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			phase   <= 2'h0;
			phaseC4 <= 1'b0;
		end else begin
			phase   <= phase + 2'h1;
			phaseC4 <= (phase + 2'h1) == `EIU_PHASE_LAST;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Pins folded to active high before the synchroniser
	assign pinActive = {watchdogIn, powerFailIn, ~ext_line5_low, ext_line4_high,
		~ext_line3_low, ext_line2_high, ~ext_line1_low, ~ext_line0_low};

	eiu_pin_sampler #(
		.WIDTH(`EIU_NUM_PINS)
	) uSampler (
		.clk_sys      (clk_sys),
		.rst_b        (rst_b),
		.pinIn        (pinActive),
		.sampleStrobe (phaseC4),
		.curSample    (curSample),
		.prevSample   (prevSample),
		.sampleValid  (sampleValid)
	);

	// Inactive-then-active on consecutive samples; needs the source to hold each level a full cycle
	assign risingSample = sampleValid ? (curSample & ~prevSample) : 8'h00;

	////////////////////////////////////////////////////////////////////////////
	// Register decode
	assign wrTimer       = sfrWrite & isAddr(sfrAddr, `EIU_ADDR_TIMER_CONTROL);
	assign wrFlag        = sfrWrite & isAddr(sfrAddr, `EIU_ADDR_FLAG);
	assign wrStdEnable   = sfrWrite & isAddr(sfrAddr, `EIU_ADDR_STD_ENABLE);
	assign wrStdPriority = sfrWrite & isAddr(sfrAddr, `EIU_ADDR_STD_PRIORITY);
	assign wrControl     = sfrWrite & isAddr(sfrAddr, `EIU_ADDR_CONTROL);
	assign wrEnable      = sfrWrite & isAddr(sfrAddr, `EIU_ADDR_ENABLE);
	assign wrPriority    = sfrWrite & isAddr(sfrAddr, `EIU_ADDR_PRIORITY);

	assign global_mask_bit    = std_enable_reg[`EIU_BIT_GLOBAL_MASK];
	assign line0_trigger_type = timerControlLow[`EIU_BIT_LINE0_TRIGGER];
	assign line1_trigger_type = timerControlLow[`EIU_BIT_LINE1_TRIGGER];
	assign line0_flag         = timerControlLow[`EIU_BIT_LINE0_FLAG];
	assign line1_flag         = timerControlLow[`EIU_BIT_LINE1_FLAG];

	// Reserved bits: bit 3 of the flag register reads one, bits 2..0 zero
	assign ext_irq_flag_reg    = {lineFlags, 4'h8};
	assign ext_irq_control_reg = {serial1_rate_doubler, 1'b1, power_fail_enable, powerFailFlag, watchdogFlag, 3'h0};

	////////////////////////////////////////////////////////////////////////////
	// Enable and priority registers, rate doubler
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			std_enable_reg       <= `EIU_RST_STD_ENABLE;
			std_priority_reg     <= `EIU_RST_STD_PRIORITY;
			ext_irq_enable_reg   <= `EIU_RST_EXT_ENABLE;
			ext_irq_priority_reg <= `EIU_RST_EXT_PRIORITY;
			power_fail_enable    <= 1'b0;
			serial1_rate_doubler <= 1'b0;
		end else begin
			if (wrStdEnable) begin
				std_enable_reg <= sfrWrData;
			end
			if (wrStdPriority) begin
				std_priority_reg <= sfrWrData[6:0];
			end
			if (wrEnable) begin
				ext_irq_enable_reg <= sfrWrData[4:0];
			end
			if (wrPriority) begin
				ext_irq_priority_reg <= sfrWrData[4:0];
			end
			if (wrControl) begin
				power_fail_enable    <= sfrWrData[`EIU_BIT_PF_ENABLE];
				serial1_rate_doubler <= sfrWrData[`EIU_BIT_RATE_DOUBLER];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Detection events for lines zero and one
	assign line0Set = sampleValid & (line0_trigger_type ? risingSample[0] : curSample[0]);
	assign line1Set = sampleValid & (line1_trigger_type ? risingSample[1] : curSample[1]);
	// Edge-mode flags clear as the call to their routine starts
	assign line0AckClear = irqAck & (irqSource == 4'h1) & line0_trigger_type;
	assign line1AckClear = irqAck & (irqSource == 4'h3) & line1_trigger_type;
	assign lineSet       = risingSample[5:2];

	////////////////////////////////////////////////////////////////////////////
	// Next flag values; a hardware set in the cycle of a clearing write wins
	always @* begin
		next_timerControlLow = timerControlLow;
		next_lineFlags       = lineFlags;
		next_powerFailFlag   = powerFailFlag;
		next_watchdogFlag    = watchdogFlag;
		if (wrTimer) begin
			next_timerControlLow = sfrWrData[3:0];
		end
		if (line0AckClear) begin
			next_timerControlLow[`EIU_BIT_LINE0_FLAG] = 1'b0;
		end
		if (line1AckClear) begin
			next_timerControlLow[`EIU_BIT_LINE1_FLAG] = 1'b0;
		end
		// Level mode is not latched: flag follows each sample
		if (sampleValid & ~line0_trigger_type) begin
			next_timerControlLow[`EIU_BIT_LINE0_FLAG] = curSample[0];
		end else if (line0Set) begin
			next_timerControlLow[`EIU_BIT_LINE0_FLAG] = 1'b1;
		end
		if (sampleValid & ~line1_trigger_type) begin
			next_timerControlLow[`EIU_BIT_LINE1_FLAG] = curSample[1];
		end else if (line1Set) begin
			next_timerControlLow[`EIU_BIT_LINE1_FLAG] = 1'b1;
		end
		if (wrFlag) begin
			next_lineFlags = sfrWrData[7:4];
		end
		next_lineFlags = next_lineFlags | lineSet;
		if (wrControl) begin
			next_powerFailFlag = sfrWrData[`EIU_BIT_PF_FLAG];
			next_watchdogFlag  = sfrWrData[`EIU_BIT_WD_FLAG];
		end
		if (sampleValid & curSample[6]) begin
			next_powerFailFlag = 1'b1;
		end
		if (risingSample[7]) begin
			next_watchdogFlag = 1'b1;
		end
	end

	// Flags leave the set state by software, vectoring or an inactive level-mode sample; no clear on return
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			timerControlLow <= `EIU_RST_TIMER_LOW;
			lineFlags       <= `EIU_RST_LINE_FLAGS;
			powerFailFlag   <= 1'b0;
			watchdogFlag    <= 1'b0;
		end else begin
			timerControlLow <= next_timerControlLow;
			lineFlags       <= next_lineFlags;
			powerFailFlag   <= next_powerFailFlag;
			watchdogFlag    <= next_watchdogFlag;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Gated requests in natural order; power-fail ignores the global mask
	assign reqVec[0]  = powerFailFlag & power_fail_enable;
	assign reqVec[1]  = global_mask_bit & line0_flag & std_enable_reg[0];
	assign reqVec[2]  = global_mask_bit & timer0_overflow_flag & std_enable_reg[1];
	assign reqVec[3]  = global_mask_bit & line1_flag & std_enable_reg[2];
	assign reqVec[4]  = global_mask_bit & timer1_overflow_flag & std_enable_reg[3];
	assign reqVec[5]  = global_mask_bit & (serial0_tx_flag | serial0_rx_flag) & std_enable_reg[4];
	assign reqVec[6]  = global_mask_bit & (timer2_overflow_flag | timer2_external_flag) & std_enable_reg[5];
	assign reqVec[7]  = global_mask_bit & (serial1_tx_flag | serial1_rx_flag) & std_enable_reg[6];
	assign reqVec[11:8] = {4{global_mask_bit}} & lineFlags & ext_irq_enable_reg[3:0];
	assign reqVec[12] = global_mask_bit & watchdogFlag & ext_irq_enable_reg[4];

	assign highVec = {ext_irq_priority_reg, std_priority_reg, 1'b1};

	eiu_priority_resolver uResolver (
		.reqVec   (reqVec),
		.highVec  (highVec),
		.winValid (winValid),
		.winIndex (winIndex),
		.winLevel (winLevel)
	);

	////////////////////////////////////////////////////////////////////////////
	// Preemption: only a strictly higher level than the deepest active routine
	assign activeLevel = inService[2] ? `EIU_LEVEL_HIGHEST :
		inService[1] ? `EIU_LEVEL_HIGH :
		inService[0] ? `EIU_LEVEL_LOW : `EIU_LEVEL_NONE;
	assign canPreempt = (activeLevel == `EIU_LEVEL_NONE) | (winLevel > activeLevel);

	// One extra instruction after a return or an enable/priority write
	assign holdEvent = return_from_isr | wrStdEnable | wrStdPriority | wrEnable | wrPriority;

	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			pendingHold <= 1'b0;
			holdOff     <= 1'b0;
		end else begin
			if (instrDone) begin
				holdOff     <= pendingHold | holdEvent;
				pendingHold <= 1'b0;
			end else if (holdEvent) begin
				pendingHold <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// In-service markers per level; return retires the deepest one
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			inService <= 3'h0;
		end else begin
			if (return_from_isr) begin
				if (inService[2]) begin
					inService[2] <= 1'b0;
				end else if (inService[1]) begin
					inService[1] <= 1'b0;
				end else begin
					inService[0] <= 1'b0;
				end
			end
			if (irqAck & irqRequest) begin
				inService[irqSource == 4'h0 ? 2 : (highVec[irqSource] ? 1 : 0)] <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Request and vector towards the sequencer; dropped for the cycle after an acknowledge
	// so the cleared flag is seen before the next decision
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			irqRequest <= 1'b0;
			irqVector  <= 8'h00;
			irqSource  <= 4'h0;
		end else begin
			irqRequest <= winValid & canPreempt & ~holdOff & ~pendingHold & ~holdEvent & ~irqAck;
			if (~irqAck) begin
				irqSource <= winIndex;
				irqVector <= {1'b0, slotOf(winIndex), 3'h3};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read mux; answer appears one clock after the address
	always @* begin
		next_hit      = 1'b1;
		next_readData = 8'h00;
		case (sfrAddr)
			`EIU_ADDR_TIMER_CONTROL: begin
				next_readData = {timer1_overflow_flag, 1'b0, timer0_overflow_flag, 1'b0, timerControlLow};
			end
			`EIU_ADDR_FLAG: begin
				next_readData = ext_irq_flag_reg;
			end
			`EIU_ADDR_STD_ENABLE: begin
				next_readData = std_enable_reg;
			end
			`EIU_ADDR_STD_PRIORITY: begin
				next_readData = {1'b1, std_priority_reg};
			end
			`EIU_ADDR_CONTROL: begin
				next_readData = ext_irq_control_reg;
			end
			`EIU_ADDR_ENABLE: begin
				next_readData = {3'h7, ext_irq_enable_reg};
			end
			`EIU_ADDR_PRIORITY: begin
				next_readData = {3'h7, ext_irq_priority_reg};
			end
			default: begin
				next_hit = 1'b0;
			end
		endcase
	end

	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			sfrReadData <= 8'h00;
			sfrHit      <= 1'b0;
		end else begin
			sfrReadData <= next_readData;
			sfrHit      <= next_hit;
		end
	end
endmodule // eiu_top
`default_nettype wire

// >>> test/eiu_cpu_model.sv
// Instruction sequencer model facing the interrupt unit
`timescale 1ns/1ps
`default_nettype none
module eiu_cpu_model (
	input  wire logic clk_sys,
	input  wire logic rst_b,
	input  wire logic irqRequest,
	input  wire logic ackOn,
	input  wire logic retiReq,
	output var  logic instrDone,
	output var  logic irqAck,
	output var  logic return_from_isr
);
	logic [1:0] phase;
	// One instruction per four clocks; ackOn low withholds every acknowledge
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			phase <= 2'h0;
			instrDone <= 1'b0;
			irqAck <= 1'b0;
			return_from_isr <= 1'b0;
		end else begin
			phase <= phase + 2'h1;
			instrDone <= (phase == 2'h3);
			return_from_isr <= (phase == 2'h3) && retiReq; // Return rides its own instruction end
			irqAck <= irqRequest && ackOn && !irqAck; // No second ack while the first lands
		end
	end
endmodule // eiu_cpu_model
`default_nettype wire

// >>> test/eiu_top_asserts.sv
// Port assertions of the interrupt unit
`timescale 1ns/1ps
`default_nettype none
module eiu_top_asserts (
	input wire logic       clk_sys,
	input wire logic       rst_b,
	input wire logic [7:0] sfrAddr,
	input wire logic [7:0] sfrWrData,
	input wire logic       sfrWrite,
	input wire logic [7:0] sfrReadData,
	input wire logic       instrDone,
	input wire logic       return_from_isr,
	input wire logic       irqAck,
	input wire logic       irqRequest,
	input wire logic [7:0] irqVector,
	input wire logic [3:0] irqSource,
	input wire logic       phaseC4
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	//////////////////////////////////////////////////////////////////////
	AST_VEC_PF: assert property (irqRequest && irqSource == 4'h0 |-> irqVector == 8'h33)
		else $error("power-fail vector wrong");
	AST_VEC_LOW: assert property (irqRequest && irqSource inside {[4'h1:4'h6]}
		|-> irqVector == 8'h03 + {irqSource - 4'h1, 3'h0}) else $error("low rank vector wrong");
	AST_VEC_HIGH: assert property (irqRequest && irqSource inside {[4'h7:4'hc]}
		|-> irqVector == 8'h03 + {1'b0, irqSource, 3'h0}) else $error("high rank vector wrong");
	AST_ACK_DROP: assert property (irqAck && irqRequest |=> !irqRequest)
		else $error("request held after ack");
	AST_PHASE: assert property ($rose(phaseC4) |=> !phaseC4 [*3] ##1 phaseC4)
		else $error("sample phase not one in four");
	AST_EXT_RSVD: assert property (sfrAddr == 8'he8 |=> sfrReadData[7:5] == 3'h7)
		else $error("enable register top bits");
	AST_RET_HOLD: assert property (return_from_isr && instrDone |-> ##2 !irqRequest)
		else $error("request right after return");
	AST_WR_TAKEN: assert property (sfrWrite && sfrAddr == 8'he8 ##1 sfrAddr == 8'he8
		|=> sfrReadData[4:0] == $past(sfrWrData[4:0], 2)) else $error("enable write lost");
endmodule // eiu_top_asserts
bind eiu_top eiu_top_asserts u_asserts (.clk_sys, .rst_b, .sfrAddr, .sfrWrData, .sfrWrite, .sfrReadData,
	.instrDone, .return_from_isr, .irqAck, .irqRequest, .irqVector, .irqSource, .phaseC4);
`default_nettype wire

// >>> test/tb.sv
// Self-checking bench of the extended interrupt unit
`timescale 1ns/1ps
`default_nettype none
module tb;
	typedef struct packed {logic wr; logic [7:0] a; logic [7:0] d; logic [7:0] e;} eiu_row_t;
	logic clk_sys = 1'b0, rst_b = 1'b0, sfrWrite = 1'b0, ackOn = 1'b0, retiReq = 1'b0;
	logic [7:0] sfrAddr = 8'h00, sfrWrData = 8'h00, sfrReadData, irqVector;
	logic [3:0] irqSource, k;
	logic sfrHit, irqRequest, phaseC4, serial1_rate_doubler, instrDone, irqAck, return_from_isr;
	logic ext_line0_low = 1'b1, ext_line1_low = 1'b1, ext_line3_low = 1'b1, ext_line5_low = 1'b1;
	logic ext_line2_high = 1'b0, ext_line4_high = 1'b0, powerFailIn = 1'b0, watchdogIn = 1'b0;
	logic timer0_overflow_flag = 1'b0, timer1_overflow_flag = 1'b0, timer2_overflow_flag = 1'b0;
	logic timer2_external_flag = 1'b0, serial0_tx_flag = 1'b0, serial0_rx_flag = 1'b0;
	logic serial1_tx_flag = 1'b0, serial1_rx_flag = 1'b0;
	int err_count = 0;
	int comparisons = 0;
	// Register rows: reset values first, then write and read back
	eiu_row_t rows [12] = '{'{1'b0, 8'he8, 8'h00, 8'he0}, '{1'b0, 8'hf8, 8'h00, 8'he0}, '{1'b0, 8'h91, 8'h00, 8'h08},
		'{1'b0, 8'hd8, 8'h00, 8'h40}, '{1'b0, 8'hb8, 8'h00, 8'h80}, '{1'b1, 8'he8, 8'h1f, 8'hff},
		'{1'b1, 8'hf8, 8'h1f, 8'hff}, '{1'b1, 8'hf8, 8'h00, 8'he0}, '{1'b1, 8'hd8, 8'h80, 8'hc0},
		'{1'b1, 8'hd8, 8'h00, 8'h40}, '{1'b1, 8'h90, 8'h55, 8'h00}, '{1'b1, 8'h88, 8'h05, 8'h05}};
	eiu_top dut (.clk_sys, .rst_b, .sfrAddr, .sfrWrData, .sfrWrite, .sfrReadData, .sfrHit, .ext_line0_low,
		.ext_line1_low, .ext_line2_high, .ext_line3_low, .ext_line4_high, .ext_line5_low, .powerFailIn, .watchdogIn,
		.timer0_overflow_flag, .timer1_overflow_flag, .timer2_overflow_flag, .timer2_external_flag, .serial0_tx_flag,
		.serial0_rx_flag, .serial1_tx_flag, .serial1_rx_flag, .instrDone, .return_from_isr, .irqAck, .irqRequest,
		.irqVector, .irqSource, .phaseC4, .serial1_rate_doubler);
	eiu_cpu_model cpu (.clk_sys, .rst_b, .irqRequest, .ackOn, .retiReq, .instrDone, .irqAck, .return_from_isr);
	// 40 MHz clock
	always #12.5 clk_sys = ~clk_sys;
	//////////////////////////////////////////////////////////////////////
	task automatic check(input string n, input logic [7:0] e, input logic [7:0] s);
		comparisons++;
		if (s !== e) begin
			err_count++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		sfrAddr <= a;
		sfrWrData <= d;
		sfrWrite <= 1'b1;
		@(posedge clk_sys);
		sfrWrite <= 1'b0;
	endtask
	// Read data lands one clock after the address is taken
	task automatic sfr_chk(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk_sys);
		sfrAddr <= a;
		@(posedge clk_sys);
		@(negedge clk_sys);
		check("read", e, sfrReadData);
		check("hit", {7'h0, a inside {8'h88, 8'h91, 8'ha8, 8'hb8, 8'hd8, 8'he8, 8'hf8}}, {7'h0, sfrHit});
	endtask
	// Hold-off after writes and returns delays the request, hence the bounded poll
	// An acknowledged request stands only two cycles, so polling starts at once
	task automatic wait_req(input logic [3:0] src, input logic [7:0] vec);
		int i;
		@(negedge clk_sys);
		for (i = 0; i < 60 && irqRequest !== 1'b1; i++) @(negedge clk_sys);
		check("request", 8'h01, {7'h0, irqRequest});
		check("source", {4'h0, src}, {4'h0, irqSource});
		check("vector", vec, irqVector);
	endtask
	task automatic quiet();
		logic seen;
		seen = 1'b0;
		repeat (4) @(posedge clk_sys);
		repeat (24) begin
			@(negedge clk_sys);
			seen = seen | irqRequest;
		end
		check("quiet", 8'h00, {7'h0, seen});
	endtask
	task automatic retire();
		int i;
		@(posedge clk_sys);
		retiReq <= 1'b1;
		for (i = 0; i < 8 && return_from_isr !== 1'b1; i++) @(negedge clk_sys);
		@(posedge clk_sys);
		retiReq <= 1'b0;
	endtask
	task automatic complete_run();
		$display("comparisons %0d err_count %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	//////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (8) @(posedge clk_sys);
		rst_b <= 1'b1;
		foreach (rows[i]) begin
			if (rows[i].wr) sfr_wr(rows[i].a, rows[i].d);
			sfr_chk(rows[i].a, rows[i].e);
			if (rows[i].a == 8'hd8) check("doubler", {7'h0, rows[i].d[7]}, {7'h0, serial1_rate_doubler});
		end
		sfr_wr(8'ha8, 8'h80);
		sfr_wr(8'he8, 8'h0f);
		for (k = 4'h0; k < 4'h4; k++) begin
			sfr_wr(8'h91, 8'h10 << k);
			wait_req(4'h8 + k, 8'h43 + {1'b0, k, 3'h0});
			sfr_wr(8'h91, 8'h00);
		end
		sfr_wr(8'h91, 8'hf0);
		wait_req(4'h8, 8'h43);
		sfr_wr(8'hf8, 8'h08);
		wait_req(4'hb, 8'h5b);
		@(posedge clk_sys);
		ackOn <= 1'b1;
		quiet();
		sfr_wr(8'ha8, 8'h00);
		powerFailIn <= 1'b1;
		quiet();
		sfr_wr(8'hd8, 8'h20);
		wait_req(4'h0, 8'h33);
		repeat (4) @(posedge clk_sys);
		powerFailIn <= 1'b0;
		retire();
		wait_req(4'h0, 8'h33);
		quiet();
		sfr_wr(8'hd8, 8'h20);
		retire();
		retire();
		sfr_wr(8'h91, 8'h00);
		{ext_line2_high, ext_line3_low, watchdogIn, ext_line0_low} <= 4'ha;
		repeat (12) @(posedge clk_sys);
		sfr_chk(8'h91, 8'h38);
		sfr_chk(8'hd8, 8'h68);
		sfr_chk(8'h88, 8'h07);
		@(posedge clk_sys);
		{ext_line2_high, ext_line3_low, watchdogIn, ext_line0_low} <= 4'h5;
		repeat (12) @(posedge clk_sys);
		sfr_chk(8'h91, 8'h38);
		sfr_wr(8'ha8, 8'h82);
		{timer0_overflow_flag, timer1_overflow_flag, timer2_overflow_flag, timer2_external_flag} <= 4'hf;
		{serial0_tx_flag, serial0_rx_flag, serial1_tx_flag, serial1_rx_flag} <= 4'hf;
		wait_req(4'h2, 8'h0b);
		complete_run();
	end
	// Watchdog against a hang
	initial begin
		repeat (5000) @(posedge clk_sys);
		err_count++;
		complete_run();
	end
endmodule // tb
`default_nettype wire
